// ### design/sob_bank.sv
// Our own choice: register access over AXI4-Lite.
`include "sob_cfg.svh"

module sob_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic psm_reset,
  input wire logic [15:0] cmp_raw,
  input wire logic [15:0] supply_raw,
  input wire logic fll_locked,
  input wire logic rtc_alarm,
  input wire logic tick_16k,
  input wire logic [`SOB_TICKS-1:0] tick_normal,
  output logic [15:0] cmp_to_debounce,
  output logic [15:0] supply_to_debounce,
  output logic lock_ok,
  output logic alarm_out,
  output logic [`SOB_TICKS-1:0] deb_tick
);
  function automatic sob_pkg::sob_word_t merge(input sob_pkg::sob_word_t old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
    sob_pkg::sob_word_t res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge

  // ****************************************************************
  // Write channel
  // ****************************************************************
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  sob_pkg::sob_resp_t bresp_q, bresp_d;
  sob_pkg::sob_idx_t waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic wr_go;
  assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && awready_q) begin
      aw_hold_d = 1'b1;
      waddr_d = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && wready_q) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_go) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `SOB_RESP_SLVERR;
      if (waddr_q == `SOB_IDX_KEY || waddr_q == `SOB_IDX_OVR ||
          waddr_q == `SOB_IDX_STS || waddr_q == `SOB_IDX_CTRL) begin
        bresp_d = `SOB_RESP_OKAY;
      end
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d = !w_hold_d && !bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `SOB_RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
    end
  end

  // ****************************************************************
  // Register bank
  // ****************************************************************
  sob_pkg::sob_word_t key_q, key_d, ovr_q, ovr_d, sts_q, sts_d;
  logic gen_q, gen_d;
  logic unlocked;
  assign unlocked = key_q == `SOB_UNLOCK;
  always_comb begin
    key_d = key_q;
    ovr_d = ovr_q;
    sts_d = sts_q;
    gen_d = gen_q;
    if (wr_go) begin
      if (waddr_q == `SOB_IDX_KEY) begin
        key_d = merge(key_q, wdata_q, wstrb_q);
      end
      if (unlocked) begin
        if (waddr_q == `SOB_IDX_OVR) begin
          ovr_d = merge(ovr_q, wdata_q, wstrb_q) & (`SOB_OVR_CMP_MASK | `SOB_OVR_CTL_MASK);
        end
        if (waddr_q == `SOB_IDX_STS) begin
          sts_d = merge(sts_q, wdata_q, wstrb_q) & `SOB_STS_MASK;
        end
        if (waddr_q == `SOB_IDX_CTRL && wstrb_q[0]) begin
          gen_d = wdata_q[`SOB_BIT_GEN];
        end
      end
    end
    if (psm_reset) begin
      key_d = `SOB_KEY_RST;
      sts_d = `SOB_STS_RST;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_q <= `SOB_KEY_RST;
      ovr_q <= `SOB_OVR_RST;
      sts_q <= `SOB_STS_RST;
      gen_q <= 1'b0;
    end else begin
      key_q <= key_d;
      ovr_q <= ovr_d;
      sts_q <= sts_d;
      gen_q <= gen_d;
    end
  end

  // ****************************************************************
  // Signal forcing
  // ****************************************************************
  // Raw samples feed readback; the status copy obeys the state machine
  // reset so software never sees stale converter state after it.
  sob_pkg::sob_word_t cmp_raw_q, cmp_raw_d, sts_raw_q, sts_raw_d;
  sob_pkg::sob_word_t cmp_deb_q, cmp_deb_d, sup_deb_q, sup_deb_d;
  logic lock_q, lock_d, alarm_q, alarm_d;
  logic [`SOB_TICKS-1:0] tick_q, tick_d;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_bit
      localparam sob_pkg::sob_word_t CM = `SOB_OVR_CMP_MASK;
      localparam sob_pkg::sob_word_t SM = `SOB_STS_MASK;
      assign cmp_deb_d[gi] = CM[gi] & (gen_q ? ovr_q[gi] : cmp_raw[gi]);
      assign sup_deb_d[gi] = SM[gi] & (gen_q ? sts_q[gi] : supply_raw[gi]);
      assign cmp_raw_d[gi] = CM[gi] & cmp_raw[gi];
      assign sts_raw_d[gi] = SM[gi] & supply_raw[gi] & !psm_reset;
    end
  endgenerate
  always_comb begin
    lock_d = ovr_q[`SOB_BIT_LOCK] | fll_locked;
    tick_d = ovr_q[`SOB_BIT_TICK] ? {`SOB_TICKS{tick_16k}} : tick_normal;
    alarm_d = ovr_q[`SOB_BIT_ALARM] | rtc_alarm;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_raw_q <= '0;
      sts_raw_q <= '0;
      cmp_deb_q <= '0;
      sup_deb_q <= '0;
      lock_q <= 1'b0;
      alarm_q <= 1'b0;
      tick_q <= '0;
    end else begin
      cmp_raw_q <= cmp_raw_d;
      sts_raw_q <= sts_raw_d;
      cmp_deb_q <= cmp_deb_d;
      sup_deb_q <= sup_deb_d;
      lock_q <= lock_d;
      alarm_q <= alarm_d;
      tick_q <= tick_d;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  sob_pkg::sob_resp_t rresp_q, rresp_d;
  sob_pkg::sob_idx_t ridx;
  assign ridx = s_axi_araddr[11:2];
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = `SOB_RESP_OKAY;
      rdata_d = '0;
      unique case (ridx)
        `SOB_IDX_KEY: rdata_d[15:0] = key_q;
        `SOB_IDX_OVR: rdata_d[15:0] = cmp_raw_q | (ovr_q & `SOB_OVR_CTL_MASK);
        `SOB_IDX_STS: rdata_d[15:0] = sts_raw_q;
        `SOB_IDX_CTRL: rdata_d[`SOB_BIT_GEN] = gen_q;
        default: rresp_d = `SOB_RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `SOB_RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign cmp_to_debounce = cmp_deb_q;
  assign supply_to_debounce = sup_deb_q;
  assign lock_ok = lock_q;
  assign alarm_out = alarm_q;
  assign deb_tick = tick_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_locked_ovr;
    wr_go && !unlocked && waddr_q == `SOB_IDX_OVR |=> $stable(ovr_q);
  endproperty
  a_locked_ovr: assert property (p_locked_ovr) else $error("locked write changed overrides");
  property p_unlock_write;
    wr_go && unlocked && !psm_reset && waddr_q == `SOB_IDX_STS && wstrb_q[1:0] == 2'h3
      |=> sts_q == ($past(wdata_q[15:0]) & `SOB_STS_MASK);
  endproperty
  a_unlock_write: assert property (p_unlock_write) else $error("unlocked write lost");
  property p_key_clear;
    psm_reset |=> key_q == `SOB_KEY_RST && !unlocked;
  endproperty
  a_key_clear: assert property (p_key_clear) else $error("key not cleared");
  property p_sts_clear;
    psm_reset |=> sts_q == `SOB_STS_RST && sts_raw_q == `SOB_STS_RST
      ##1 sup_deb_q == ($past(gen_q) ? `SOB_STS_RST : ($past(supply_raw) & `SOB_STS_MASK));
  endproperty
  a_sts_clear: assert property (p_sts_clear) else $error("status not cleared");
  property p_force_path;
    gen_q |=> cmp_to_debounce == ($past(ovr_q) & `SOB_OVR_CMP_MASK);
  endproperty
  a_force_path: assert property (p_force_path) else $error("force not applied");
  property p_raw_read;
    s_axi_arvalid && arready_q && ridx == `SOB_IDX_OVR
      |=> (s_axi_rdata[15:0] & `SOB_OVR_CMP_MASK) == $past(cmp_raw_q);
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw readback wrong");
  property p_lock;
    ovr_q[`SOB_BIT_LOCK] |=> lock_ok;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not forced");
  property p_tick;
    ovr_q[`SOB_BIT_TICK] |=> deb_tick == {`SOB_TICKS{$past(tick_16k)}};
  endproperty
  a_tick: assert property (p_tick) else $error("tick not replaced");
  property p_alarm;
    !ovr_q[`SOB_BIT_ALARM] |=> alarm_out == $past(rtc_alarm);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not normal");
endmodule : sob_bank

// ### design/sob_cfg.svh
`ifndef SOB_CFG_SVH
`define SOB_CFG_SVH
// Printed register indices; the byte address is four times the index.
`define SOB_IDX_KEY 10'h0db
`define SOB_IDX_OVR 10'h0e0
`define SOB_IDX_STS 10'h0e1
`define SOB_IDX_CTRL 10'h0e8
`define SOB_UNLOCK 16'h0013
`define SOB_KEY_RST 16'h0000
`define SOB_OVR_RST 16'h0000
`define SOB_STS_RST 16'h0000
// Comparator force bits of the override register: 11, 10, 7, 3..0.
`define SOB_OVR_CMP_MASK 16'h0c8f
`define SOB_OVR_CTL_MASK 16'h0340
`define SOB_BIT_LOCK 9
`define SOB_BIT_TICK 8
`define SOB_BIT_ALARM 6
// Limit switch 15, regulators 11..8, converters 5..0.
`define SOB_STS_MASK 16'h8f3f
`define SOB_BIT_GEN 0
`define SOB_TICKS 4
`define SOB_RESP_OKAY 2'h0
`define SOB_RESP_SLVERR 2'h2
`endif

// ### design/sob_pkg.sv
package sob_pkg;
  typedef logic [15:0] sob_word_t;
  typedef logic [9:0] sob_idx_t;
  typedef logic [1:0] sob_resp_t;
endpackage : sob_pkg

// ### tb/sob_analog_model.sv
`include "sob_cfg.svh"

// ****************************************
// Analog and timing side of the bank
// ****************************************
module sob_analog_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick_16k,
  output logic [`SOB_TICKS-1:0] tick_normal,
  output logic fll_locked,
  output logic rtc_alarm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // fast tick source
  // The fast tick is shortened to one in eight cycles so that runs stay brief.
  assign tick_16k = (cnt_q[2:0] == 3'h0);
  // Normal ticks change on all but one cycle in sixteen so a stuck tick selection shows at once.
  assign tick_normal = cnt_q[`SOB_TICKS-1:0] ^ {`SOB_TICKS{cnt_q[4]}};
  assign fll_locked = cnt_q[2];
  assign rtc_alarm = cnt_q[3];
endmodule : sob_analog_model

// ### tb/tb.sv
`include "sob_cfg.svh"

// ****************************************
// Register bank bench
// ****************************************
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] AK = {`SOB_IDX_KEY, 2'b00};
  localparam logic [11:0] AO = {`SOB_IDX_OVR, 2'b00};
  localparam logic [11:0] AS = {`SOB_IDX_STS, 2'b00};
  localparam logic [11:0] AC = {`SOB_IDX_CTRL, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic psm_reset = 1'b0;
  logic [15:0] cmp_raw = 16'h0, supply_raw = 16'h0;
  logic awready, wready, bvalid, arready, rvalid, tick_16k, fll_locked, rtc_alarm;
  logic lock_ok, alarm_out;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] cmp_to_debounce, supply_to_debounce;
  logic [`SOB_TICKS-1:0] tick_normal, deb_tick;
  int n_mismatch = 0;
  int samples_checked = 0;

  sob_bank i_sob_bank (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .psm_reset(psm_reset), .cmp_raw(cmp_raw),
    .supply_raw(supply_raw), .fll_locked(fll_locked), .rtc_alarm(rtc_alarm),
    .tick_16k(tick_16k), .tick_normal(tick_normal), .cmp_to_debounce(cmp_to_debounce),
    .supply_to_debounce(supply_to_debounce), .lock_ok(lock_ok), .alarm_out(alarm_out),
    .deb_tick(deb_tick));

  sob_analog_model i_sob_analog_model (.aclk(aclk), .aresetn(aresetn),
    .tick_16k(tick_16k), .tick_normal(tick_normal), .fll_locked(fll_locked),
    .rtc_alarm(rtc_alarm));

  initial begin
    forever #10 aclk = ~aclk;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // Address and data are offered together and each is dropped once taken.
  // Only the watchdog ends a wait for the answer.
  task wr(input logic [11:0] a, input logic [15:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0, v};
    wstrb <= 4'h3;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask : wr

  task rd(input logic [11:0] a, input logic [15:0] ev, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    chk("rdata", rdata, {16'h0, ev});
  endtask : rd

  // Outputs are registered, so each is judged against inputs held one cycle before.
  task side_chk(input logic fl, input logic fa, input logic ft);
    logic l, al, t;
    logic [`SOB_TICKS-1:0] tn;
    repeat (8) begin
      @(negedge aclk);
      l = fll_locked;
      al = rtc_alarm;
      t = tick_16k;
      tn = tick_normal;
      @(negedge aclk);
      chk("lock_ok", {31'h0, lock_ok}, {31'h0, fl | l});
      chk("alarm_out", {31'h0, alarm_out}, {31'h0, fa | al});
      chk("deb_tick", 32'(deb_tick), 32'(ft ? {`SOB_TICKS{t}} : tn));
    end
  endtask : side_chk

  task settle;
    repeat (3) @(posedge aclk);
  endtask : settle

  initial begin
    #200us;
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(AK, `SOB_KEY_RST, `SOB_RESP_OKAY);
    rd(AO, `SOB_OVR_RST, `SOB_RESP_OKAY);
    rd(AS, `SOB_STS_RST, `SOB_RESP_OKAY);
    rd(12'h004, 16'h0, `SOB_RESP_SLVERR);
    wr(12'h004, 16'h0013, `SOB_RESP_SLVERR);
    side_chk(1'b0, 1'b0, 1'b0);
    wr(AO, 16'h0340, `SOB_RESP_OKAY);
    rd(AO, 16'h0000, `SOB_RESP_OKAY);
    wr(AK, `SOB_UNLOCK, `SOB_RESP_OKAY);
    rd(AK, `SOB_UNLOCK, `SOB_RESP_OKAY);
    wr(AO, 16'h0fcf, `SOB_RESP_OKAY);
    rd(AO, `SOB_OVR_CTL_MASK, `SOB_RESP_OKAY);
    side_chk(1'b1, 1'b1, 1'b1);
    @(posedge aclk);
    cmp_raw <= 16'hffff;
    supply_raw <= 16'hffff;
    settle();
    rd(AO, `SOB_OVR_CMP_MASK | `SOB_OVR_CTL_MASK, `SOB_RESP_OKAY);
    rd(AS, `SOB_STS_MASK, `SOB_RESP_OKAY);
    cmp_raw <= 16'h0;
    supply_raw <= 16'h0;
    wr(AS, 16'hffff, `SOB_RESP_OKAY);
    wr(AC, 16'h0001, `SOB_RESP_OKAY);
    settle();
    chk("cmp_to_debounce", 32'(cmp_to_debounce), 32'(`SOB_OVR_CMP_MASK));
    chk("supply_to_debounce", 32'(supply_to_debounce), 32'(`SOB_STS_MASK));
    wr(AC, 16'h0000, `SOB_RESP_OKAY);
    cmp_raw <= 16'h0480;
    settle();
    chk("cmp_to_debounce", 32'(cmp_to_debounce), 32'h0480);
    wr(AC, 16'h0001, `SOB_RESP_OKAY);
    @(posedge aclk);
    psm_reset <= 1'b1;
    @(posedge aclk);
    psm_reset <= 1'b0;
    settle();
    chk("supply_to_debounce", 32'(supply_to_debounce), 32'h0);
    rd(AK, 16'h0000, `SOB_RESP_OKAY);
    wr(AO, 16'h0000, `SOB_RESP_OKAY);
    // Raw comparators still read back beside the unchanged stored force bits.
    rd(AO, 16'h0340 | 16'h0480, `SOB_RESP_OKAY);
    final_report();
  end
endmodule : tb
